// [ccr_pkg.sv]
// Constants, register map and state types for the CAN control/command block.
// Assumes a 32-bit APB with one aligned word per register, byte address = 4 * index.
package ccr_pkg;

  // ----------------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------------
  localparam int unsigned CCR_IDX_CONTROL = 0;  // mode_and_irq_control
  localparam int unsigned CCR_IDX_COMMAND = 1;  // command_strobe
  localparam int unsigned CCR_ADDR_SCALE  = 4;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int unsigned CCR_CR_RESET_REQ = 0;
  localparam int unsigned CCR_CR_RX_IRQ_EN = 1;
  localparam int unsigned CCR_CR_FIXED_ONE = 5;
  localparam int unsigned CCR_CR_SYNC_SEL  = 6;
  localparam int unsigned CCR_CR_TOP_RSVD  = 7;

  // ----------------------------------------------------------------------
  // Command register fields
  // ----------------------------------------------------------------------
  localparam int unsigned CCR_CMD_SEND    = 0;
  localparam int unsigned CCR_CMD_ABORT   = 1;
  localparam int unsigned CCR_CMD_RELEASE = 2;
  localparam int unsigned CCR_CMD_CLR_OVR = 3;
  localparam int unsigned CCR_CMD_SLEEP   = 4;

  // ----------------------------------------------------------------------
  // Read values and counts
  // ----------------------------------------------------------------------
  localparam logic [31:0] CCR_CMD_READ_VAL   = 32'h0000_00ff;
  localparam logic [7:0]  CCR_FREE_SHORT     = 8'h01;  // One bus-free after host reset
  localparam logic [7:0]  CCR_FREE_LONG      = 8'h80;  // 128 bus-free after bus-off
  localparam logic [4:0]  CCR_CLOCK_OUTPUT_PIN_BITS    = 5'h0f;  // Bit times before clock output stops
  localparam logic        CCR_RIE_RESET      = 1'b0;

  // ----------------------------------------------------------------------
  // Operating mode
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    CCR_MD_RESET = 4'b0001,
    CCR_MD_WAIT  = 4'b0010,
    CCR_MD_RUN   = 4'b0100,
    CCR_MD_SLEEP = 4'b1000
  } ccr_mode_e;

endpackage

// [ccr_control_command_regs.sv]
// Control and command register logic of a stand-alone CAN controller.
// Assumes i_clk is the internal (half oscillator) clock and that the protocol
// engine, filters and FIFO sit outside and talk over the level/pulse ports.
//
// Contract
// [R1] Receive interrupt when enabled and message good
// [R2] Reset request aborts traffic, enters reset
// [R3] Falling reset request returns to operation
// [R4] Host writes zero to top control bit
// [R5] Sync-select bit stored, no effect, survives reset
// [R6] Third reserved control bit reads one
// [R7] Hardware reset or bus-off forces reset request
// [R8] Reset request change registered, read synchronized
// [R9] External reset low blocks clearing reset request
// [R10] One bus-free before bus-on after reset
// [R11] 128 bus-free before bus-on after bus-off
// [R12] Command register write-only, reads all ones
// [R13] Host spaces command writes one cycle apart
// [R14] Sleep only if idle, else wake interrupt
// [R15] Clock output runs 15 bit times asleep
// [R16] Wake on clear, activity or irq pin
// [R17] Bus wake blocks frames until bus-free
// [R18] Sleep ignored in reset and until bus-free
// [R19] Clear overrun; no repeat overrun interrupt
// [R20] Release frees FIFO slot, maybe new interrupt
// [R21] Abort cancels only a not-started request
// [R22] Send request starts; zero does not cancel
// [R23] Send request clears done until success
// [R24] Receive status set again after release
// [R25] Command bits pulse; sleep bit holds level

`timescale 1ns/1ns

module ccr_control_command_regs
  import ccr_pkg::*;
#(
  parameter int unsigned APB_AW = 8
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  // APB slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [APB_AW-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic                   o_pready,
  output logic [31:0]            o_prdata,
  output logic                   o_pslverr,
  // Pins and bus status
  input  wire logic              i_ext_rst_n,
  input  wire logic              i_irq_pin_low,
  input  wire logic              i_bus_off,
  input  wire logic              i_bus_free,
  input  wire logic              i_bus_idle,
  input  wire logic              i_bus_activity,
  input  wire logic              i_bit_tick,
  input  wire logic              i_irq_pending,
  // Protocol engine and FIFO events
  input  wire logic              i_rx_msg_ok,
  input  wire logic              i_fifo_msg_avail,
  input  wire logic              i_overrun_event,
  input  wire logic              i_tx_in_progress,
  input  wire logic              i_tx_success,
  // Mode outputs
  output logic                   o_reset_mode,
  output logic                   o_bus_on,
  output logic                   o_sleep,
  output logic                   o_clock_output_pin_en,
  output logic                   o_frame_accept,
  output logic                   o_osc_restart,
  // Command and status outputs
  output logic                   o_tx_request,
  output logic                   o_tx_done_status,
  output logic                   o_abort_pulse,
  output logic                   o_fifo_release,
  output logic                   o_rx_buf_status,
  output logic                   o_overrun_status,
  output logic                   o_rx_irq,
  output logic                   o_overrun_irq,
  output logic                   o_wake_irq
);

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  if (APB_AW < 3) begin : g_bad_aw
    $error("APB_AW must be at least 3");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    ccr_mode_e   mode;
    logic        rr;
    logic        rr_busoff;
    logic        receive_irq_enable;
    logic        sync_sel;
    logic [7:0]  free_cnt;
    logic        sleep_cmd;
    logic [4:0]  clk_cnt;
    logic        clock_output_pin_en;
    logic        rx_block;
    logic        rbs;
    logic        dos;
    logic        tx_pend;
    logic        tx_done;
    logic        rx_irq;
    logic        ovr_irq;
    logic        wake_irq;
    logic        osc_restart;
    logic        abort_p;
    logic        release_p;
    logic        bus_on;
    logic        frame_ok;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ccr_state_s;

  ccr_state_s st_reg;
  ccr_state_s st_next;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic [APB_AW-3:0] idx;
  logic              setup_ph;
  logic              wr_acc;
  logic              wr_ctrl;
  logic              wr_cmd;
  logic              mapped;
  logic [7:0]        free_target;

  assign idx         = i_paddr[APB_AW-1:2];
  assign setup_ph    = i_psel & ~i_penable;
  assign wr_acc      = i_psel & i_penable & st_reg.pready & i_pwrite;
  assign mapped      = (idx == (APB_AW-2)'(CCR_IDX_CONTROL)) ||
                       (idx == (APB_AW-2)'(CCR_IDX_COMMAND));
  assign wr_ctrl     = wr_acc & (idx == (APB_AW-2)'(CCR_IDX_CONTROL));
  assign wr_cmd      = wr_acc & (idx == (APB_AW-2)'(CCR_IDX_COMMAND));
  assign free_target = st_reg.rr_busoff ? CCR_FREE_LONG : CCR_FREE_SHORT;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic cmd_send;
    logic cmd_abort;
    logic cmd_rel;
    logic cmd_clr;
    logic cmd_sleep;
    logic wake;
    cmd_send  = wr_cmd & i_pwdata[CCR_CMD_SEND];
    cmd_abort = wr_cmd & i_pwdata[CCR_CMD_ABORT];
    cmd_rel   = wr_cmd & i_pwdata[CCR_CMD_RELEASE];
    cmd_clr   = wr_cmd & i_pwdata[CCR_CMD_CLR_OVR];
    cmd_sleep = wr_cmd & i_pwdata[CCR_CMD_SLEEP];
    wake      = 1'b0;
    st_next   = st_reg;
    // [R25] single-cycle command pulses
    st_next.rx_irq      = 1'b0;
    st_next.ovr_irq     = 1'b0;
    st_next.wake_irq    = 1'b0;
    st_next.osc_restart = 1'b0;
    st_next.abort_p     = cmd_abort;
    st_next.release_p   = cmd_rel;

    // APB answer, prepared in the setup cycle and shown in the access cycle
    st_next.pready  = setup_ph;
    st_next.pslverr = setup_ph & ~mapped;
    st_next.prdata  = 32'h0000_0000;
    if (setup_ph && !i_pwrite) begin
      if (idx == (APB_AW-2)'(CCR_IDX_CONTROL)) begin
        st_next.prdata[CCR_CR_RESET_REQ] = st_reg.rr;
        st_next.prdata[CCR_CR_RX_IRQ_EN] = st_reg.receive_irq_enable;
        // [R6] reserved bit reads one
        st_next.prdata[CCR_CR_FIXED_ONE] = 1'b1;
        st_next.prdata[CCR_CR_SYNC_SEL]  = st_reg.sync_sel;
      end else if (idx == (APB_AW-2)'(CCR_IDX_COMMAND)) begin
        // [R12] write-only register reads ones
        st_next.prdata = CCR_CMD_READ_VAL;
      end
    end

    // Control register write; top reserved bit is not stored
    if (wr_ctrl) begin
      st_next.receive_irq_enable = i_pwdata[CCR_CR_RX_IRQ_EN];
      // [R5] sync select stored only
      st_next.sync_sel = i_pwdata[CCR_CR_SYNC_SEL];
      // [R8] registered reset request change
      st_next.rr = i_pwdata[CCR_CR_RESET_REQ];
      if (i_pwdata[CCR_CR_RESET_REQ]) begin
        st_next.rr_busoff = 1'b0;
      end
    end
    // [R9] external reset holds request
    if (!i_ext_rst_n) begin
      st_next.rr        = 1'b1;
      st_next.rr_busoff = 1'b0;
    end
    // [R7] bus-off forces request
    if (i_bus_off) begin
      st_next.rr        = 1'b1;
      st_next.rr_busoff = 1'b1;
    end

    // Transmit request, abort and completion
    // [R21] abort only before start
    if (cmd_abort && !i_tx_in_progress) begin
      st_next.tx_pend = 1'b0;
    end
    if (i_tx_success) begin
      st_next.tx_pend = 1'b0;
      st_next.tx_done = 1'b1;
    end
    // [R22] send sets pending, zero ignored
    if (cmd_send) begin
      st_next.tx_pend = 1'b1;
      // [R23] done cleared by new request
      st_next.tx_done = 1'b0;
    end

    // Receive buffer status and interrupt
    // [R20] release frees slot
    if (cmd_rel) begin
      st_next.rbs = i_fifo_msg_avail;
      // [R24] status set again at once
    end
    if (i_rx_msg_ok) begin
      st_next.rbs = 1'b1;
    end
    // [R1] receive interrupt gated by enable
    st_next.rx_irq = st_reg.receive_irq_enable & (i_rx_msg_ok | (cmd_rel & i_fifo_msg_avail));

    // [R19] overrun set wins over clear
    st_next.ovr_irq = i_overrun_event & ~st_reg.dos;
    if (cmd_clr) begin
      st_next.dos = 1'b0;
    end
    if (i_overrun_event) begin
      st_next.dos = 1'b1;
    end

    // [R17] frames blocked until bus-free
    if (i_bus_free) begin
      st_next.rx_block = 1'b0;
    end

    // Mode sequencing
    unique case (st_reg.mode)
      CCR_MD_RESET: begin
        // [R3] leave reset on cleared request
        if (!st_reg.rr) begin
          st_next.mode     = CCR_MD_WAIT;
          st_next.free_cnt = 8'h00;
        end
      end
      CCR_MD_WAIT: begin
        // [R10] [R11] count bus-free occurrences
        if (i_bus_free) begin
          st_next.free_cnt = st_reg.free_cnt + 8'h01;
          if (st_reg.free_cnt + 8'h01 >= free_target) begin
            st_next.mode      = CCR_MD_RUN;
            st_next.rr_busoff = 1'b0;
          end
        end
      end
      CCR_MD_RUN: begin
        // [R14] sleep only when quiet
        if (cmd_sleep) begin
          if (!i_irq_pending && i_bus_idle) begin
            st_next.mode      = CCR_MD_SLEEP;
            st_next.sleep_cmd = 1'b1;
            st_next.clk_cnt   = 5'h00;
          end else begin
            st_next.wake_irq = 1'b1;
          end
        end
      end
      CCR_MD_SLEEP: begin
        // [R15] clock output kept for bit times
        if (st_reg.clock_output_pin_en && i_bit_tick) begin
          st_next.clk_cnt = st_reg.clk_cnt + 5'h01;
          if (st_reg.clk_cnt + 5'h01 >= CCR_CLOCK_OUTPUT_PIN_BITS) begin
            st_next.clock_output_pin_en = 1'b0;
          end
        end
        // [R16] three wake sources
        wake = (wr_cmd & ~i_pwdata[CCR_CMD_SLEEP]) | i_bus_activity | i_irq_pin_low;
        if (wake) begin
          st_next.mode        = CCR_MD_RUN;
          st_next.sleep_cmd   = 1'b0;
          st_next.clock_output_pin_en   = 1'b1;
          st_next.osc_restart = 1'b1;
          st_next.wake_irq    = 1'b1;
          // [R17] waking frame not received
          st_next.rx_block    = i_bus_activity;
        end
      end
    endcase

    // [R2] reset mode aborts traffic
    // [R18] sleep dropped in reset
    if (st_next.rr) begin
      st_next.mode      = CCR_MD_RESET;
      st_next.tx_pend   = 1'b0;
      st_next.sleep_cmd = 1'b0;
      st_next.clock_output_pin_en = 1'b1;
      st_next.free_cnt  = 8'h00;
      st_next.rx_block  = 1'b0;
    end
    // Decoded levels kept in flops so the outputs need no gates
    st_next.bus_on   = st_next.mode[2] | st_next.mode[3];
    st_next.frame_ok = ~st_next.rx_block;
  end

  // ----------------------------------------------------------------------
  // State register; sync select survives reset
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      // [R7] hardware reset sets request
      st_reg           <= '0;
      st_reg.mode      <= CCR_MD_RESET;
      st_reg.rr        <= 1'b1;
      st_reg.receive_irq_enable       <= CCR_RIE_RESET;
      st_reg.clock_output_pin_en <= 1'b1;
      st_reg.frame_ok  <= 1'b1;
      st_reg.sync_sel  <= st_reg.sync_sel;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------------
  assign o_pready         = st_reg.pready;
  assign o_prdata         = st_reg.prdata;
  assign o_pslverr        = st_reg.pslverr;
  assign o_reset_mode     = st_reg.mode[0];
  assign o_bus_on         = st_reg.bus_on;
  assign o_sleep          = st_reg.sleep_cmd;
  assign o_clock_output_pin_en      = st_reg.clock_output_pin_en;
  assign o_frame_accept   = st_reg.frame_ok;
  assign o_osc_restart    = st_reg.osc_restart;
  assign o_tx_request     = st_reg.tx_pend;
  assign o_tx_done_status = st_reg.tx_done;
  assign o_abort_pulse    = st_reg.abort_p;
  assign o_fifo_release   = st_reg.release_p;
  assign o_rx_buf_status  = st_reg.rbs;
  assign o_overrun_status = st_reg.dos;
  assign o_rx_irq         = st_reg.rx_irq;
  assign o_overrun_irq    = st_reg.ovr_irq;
  assign o_wake_irq       = st_reg.wake_irq;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_cmd_wr(int b);
    wr_cmd && i_pwdata[b];
  endsequence

  sequence s_enter_wait;
    o_reset_mode && !st_reg.rr ##1 st_reg.mode == CCR_MD_WAIT;
  endsequence

  a_rx_irq_gate: assert property (o_rx_irq |-> $past(st_reg.receive_irq_enable)) // [R1]
    else $error("receive interrupt while disabled");
  a_rr_reset_mode: assert property (st_reg.rr |=> o_reset_mode && !o_tx_request) // [R2]
    else $error("reset request did not enter reset mode");
  a_leave_reset: assert property (s_enter_wait |-> !o_bus_on) // [R3]
    else $error("left reset straight to bus-on");
  a_third_bit_one: assert property ( // [R6]
    o_pready && !i_pwrite && idx == (APB_AW-2)'(CCR_IDX_CONTROL) |-> o_prdata[5])
    else $error("fixed control bit read as zero");
  a_busoff_forces: assert property (i_bus_off |=> st_reg.rr && st_reg.rr_busoff) // [R7]
    else $error("bus-off did not force reset request");
  a_rr_sync_write: assert property ( // [R8]
    wr_ctrl && i_pwdata[0] |=> st_reg.rr)
    else $error("reset request write not taken next edge");
  a_ext_rst_hold: assert property (!i_ext_rst_n |=> st_reg.rr) // [R9]
    else $error("reset request cleared under external reset");
  a_short_wait: assert property ( // [R10]
    st_reg.mode == CCR_MD_WAIT && !st_reg.rr_busoff && i_bus_free && !st_next.rr
    |=> o_bus_on)
    else $error("bus-on not reached after one bus-free");
  a_long_wait: assert property ( // [R11]
    st_reg.mode == CCR_MD_WAIT && st_reg.rr_busoff && st_reg.free_cnt < 8'h7f
    |=> !o_bus_on)
    else $error("bus-on before 128 bus-free");
  a_cmd_reads_ones: assert property ( // [R12]
    o_pready && !i_pwrite && idx == (APB_AW-2)'(CCR_IDX_COMMAND) |-> o_prdata == 32'h0000_00ff)
    else $error("command register read not all ones");
  a_sleep_busy_wake: assert property ( // [R14]
    (s_cmd_wr(4) and (st_reg.mode == CCR_MD_RUN && i_irq_pending && !st_next.rr))
    |=> o_wake_irq && !o_sleep)
    else $error("busy sleep request gave no wake interrupt");
  a_clock_output_pin_hold: assert property ( // [R15]
    $rose(o_sleep) |-> o_clock_output_pin_en [*8])
    else $error("clock output stopped too early");
  a_wake_irq_pin: assert property ( // [R16]
    o_sleep && i_irq_pin_low && !st_next.rr |=> !o_sleep && o_wake_irq && o_osc_restart)
    else $error("irq pin did not wake device");
  a_bus_wake_block: assert property ( // [R17]
    o_sleep && i_bus_activity && !st_next.rr |=> !o_frame_accept)
    else $error("waking frame not blocked");
  a_no_sleep_reset: assert property (o_reset_mode |-> !o_sleep) // [R18]
    else $error("sleep held in reset mode");
  a_overrun_once: assert property (o_overrun_status |=> !o_overrun_irq) // [R19]
    else $error("repeat overrun interrupt");
  a_release_refill: assert property ( // [R20]
    (s_cmd_wr(2) and i_fifo_msg_avail) |=> o_rx_buf_status && o_fifo_release)
    else $error("release with message left lost status");
  a_abort_in_prog: assert property ( // [R21]
    (s_cmd_wr(1) and (o_tx_request && i_tx_in_progress && !i_tx_success && !st_next.rr))
    |=> o_tx_request)
    else $error("abort cancelled running transmission");
  a_send_done_clr: assert property ( // [R23]
    (s_cmd_wr(0) and !st_next.rr) |=> o_tx_request && !o_tx_done_status)
    else $error("send request did not clear done status");
  a_pulse_single: assert property ( // [R25]
    o_abort_pulse |=> !o_abort_pulse)
    else $error("abort pulse held");

endmodule

// [ccr_host_model.sv]
// Host model: APB master that issues register reads and writes.
// Assumes one clock shared with the block; the bench calls wr and rd.
`timescale 1ns/1ns
module ccr_host_model (
  // Clock
  input  wire logic        i_clk,
  // APB master side
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [7:0]       o_paddr,
  output logic [31:0]      o_pwdata,
  input  wire logic        i_pready,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pslverr
);
  // ------------------------------------------------------------
  // Bus transfer
  // ------------------------------------------------------------
  // Idle bus at time zero
  initial begin
    o_psel    = 1'b0;
    o_penable = 1'b0;
    o_pwrite  = 1'b0;
    o_paddr   = 8'h00;
    o_pwdata  = 32'h0000_0000;
  end

  // Request held until pready is seen high at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge i_clk);
    o_psel    <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite  <= w;
    o_paddr   <= a;
    o_pwdata  <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    @(posedge i_clk);
    while (i_pready !== 1'b1) @(posedge i_clk);
    q = i_prdata;
    e = i_pslverr;
    o_psel    <= 1'b0;
    o_penable <= 1'b0;
    // Stale data inverted so nothing leans on it
    o_pwdata  <= ~d;
  endtask

  // zero top bit, spacing
  // Idle edge before each setup keeps commands a cycle apart
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, a, (a == 8'h00) ? (d & 32'hffff_ff7f) : d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
    xfer(1'b0, a, 32'h0000_0000, q, e);
  endtask
endmodule

// [can_control_command_regs_tb.sv]
// Self-checking bench for the control/command register block.
// Assumes the host model drives APB; status inputs are driven here.
`timescale 1ns/1ns
module can_control_command_regs_tb;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cmd;
    logic       busy;
    logic       avail;
    logic [3:0] exp;
  } ccr_row_s;
  logic i_clk, i_sys_rst, psel, pen, pwr, rdy, err, slv_err;
  logic ext_n, irq_low, boff, idle, irq_pend, avail, busy;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, q;
  logic [5:0]  ev;
  logic rmode, bon, slp, clken, facc, osc, txreq, done, abrt, rel, rbs, ovs, rxi, ovi, wki;
  int failures, samples_checked;
  // Rows: command, tx busy, fifo avail, {txreq, abort, release, rx irq}
  ccr_row_s rows [6] = '{'{8'h01, 1'b0, 1'b0, 4'b1000}, '{8'h00, 1'b0, 1'b0, 4'b1000},
                         '{8'h02, 1'b1, 1'b0, 4'b1100}, '{8'h02, 1'b0, 1'b0, 4'b0100},
                         '{8'h04, 1'b0, 1'b1, 4'b0011}, '{8'h0c, 1'b0, 1'b0, 4'b0010}};

  ccr_host_model i_ccr_host_model (.i_clk(i_clk), .o_psel(psel), .o_penable(pen),
    .o_pwrite(pwr), .o_paddr(addr), .o_pwdata(wdata), .i_pready(rdy), .i_prdata(rdata),
    .i_pslverr(slv_err));
  ccr_control_command_regs i_ccr_control_command_regs (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr),
    .i_pwdata(wdata), .o_pready(rdy), .o_prdata(rdata), .o_pslverr(slv_err),
    .i_ext_rst_n(ext_n), .i_irq_pin_low(irq_low), .i_bus_off(boff), .i_bus_free(ev[0]),
    .i_bus_idle(idle), .i_bus_activity(ev[5]), .i_bit_tick(ev[1]),
    .i_irq_pending(irq_pend), .i_rx_msg_ok(ev[2]), .i_fifo_msg_avail(avail),
    .i_overrun_event(ev[3]), .i_tx_in_progress(busy), .i_tx_success(ev[4]),
    .o_reset_mode(rmode), .o_bus_on(bon), .o_sleep(slp), .o_clock_output_pin_en(clken),
    .o_frame_accept(facc), .o_osc_restart(osc), .o_tx_request(txreq),
    .o_tx_done_status(done), .o_abort_pulse(abrt), .o_fifo_release(rel),
    .o_rx_buf_status(rbs), .o_overrun_status(ovs), .o_rx_irq(rxi),
    .o_overrun_irq(ovi), .o_wake_irq(wki));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic fin(input string s);
    $display("%0t test %s finished", $time, s);
  endtask
  // Pulse one event input for a cycle, then settle after its sampling edge
  task automatic pls(input int k);
    @(posedge i_clk);
    ev[k] <= 1'b1;
    @(posedge i_clk);
    ev[k] <= 1'b0;
    #1;
  endtask
  task automatic nx;
    @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_ccr_host_model.wr(a, d);
    #1;
  endtask
  task automatic test_done;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Clock and watchdog; the whole run needs well under 2000 cycles
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    failures++;
    test_done;
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {i_sys_rst, ext_n, idle} = 3'b111;
    {irq_low, boff, irq_pend, avail, busy, ev} = '0;
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    nx;
    chk(32'({rmode, bon, clken, facc}), 32'h0b, "reset outputs");
    i_ccr_host_model.rd(8'h00, q, err);
    chk(q & 32'hffff_ffbf, 32'h21, "control reset read");
    i_ccr_host_model.rd(8'h04, q, err);
    chk(q, 32'hff, "command read");
    i_ccr_host_model.rd(8'h08, q, err);
    chk(32'(err), 32'h1, "unmapped error");
    wr(8'h04, 32'h10);
    chk(32'({slp, wki}), 32'h0, "sleep in reset");
    fin("reset");
    @(posedge i_clk);
    ext_n <= 1'b0;
    wr(8'h00, 32'h00);
    i_ccr_host_model.rd(8'h00, q, err);
    chk(q & 32'h1, 32'h1, "clear blocked by pin");
    @(posedge i_clk);
    ext_n <= 1'b1;
    wr(8'h00, 32'hc2);
    i_ccr_host_model.rd(8'h00, q, err);
    chk(q, 32'h62, "control readback");
    nx;
    chk(32'({rmode, bon}), 32'h0, "waiting bus free");
    pls(0);
    nx;
    chk(32'(bon), 32'h1, "bus on after one free");
    fin("leave reset");
    foreach (rows[i]) begin
      @(posedge i_clk);
      busy  <= rows[i].busy;
      avail <= rows[i].avail;
      wr(8'h04, 32'(rows[i].cmd));
      chk(32'({txreq, abrt, rel, rxi}), 32'(rows[i].exp), "command row");
    end
    @(posedge i_clk);
    busy <= 1'b0;
    fin("command rows");
    pls(2);
    chk(32'({rxi, rbs}), 32'h3, "rx irq enabled");
    wr(8'h00, 32'h40);
    pls(2);
    chk(32'(rxi), 32'h0, "rx irq disabled");
    pls(3);
    chk(32'({ovi, ovs}), 32'h3, "overrun first");
    pls(3);
    chk(32'({ovi, ovs}), 32'h1, "overrun repeat");
    wr(8'h04, 32'h08);
    chk(32'(ovs), 32'h0, "overrun cleared");
    pls(4);
    chk(32'(done), 32'h1, "tx done");
    wr(8'h04, 32'h01);
    chk(32'({done, txreq}), 32'h1, "send clears done");
    wr(8'h04, 32'h02);
    fin("events");
    @(posedge i_clk);
    irq_pend <= 1'b1;
    wr(8'h04, 32'h10);
    chk(32'({slp, wki}), 32'h1, "busy sleep wakes");
    @(posedge i_clk);
    irq_pend <= 1'b0;
    wr(8'h04, 32'h10);
    chk(32'(slp), 32'h1, "asleep");
    repeat (14) pls(1);
    chk(32'({clken, slp}), 32'h3, "clock out still on");
    pls(1);
    nx;
    chk(32'(clken), 32'h0, "clock out off");
    pls(5);
    chk(32'({slp, wki, osc, facc}), 32'h6, "bus wake");
    pls(0);
    nx;
    chk(32'(facc), 32'h1, "frames after free");
    // Interrupt pin as wake source
    wr(8'h04, 32'h10);
    @(posedge i_clk);
    irq_low <= 1'b1;
    @(posedge i_clk);
    irq_low <= 1'b0;
    #1;
    chk(32'({slp, wki, osc, facc}), 32'h7, "pin wake");
    // Command write with sleep bit low as wake source
    wr(8'h04, 32'h10);
    wr(8'h04, 32'h00);
    chk(32'({slp, wki, osc}), 32'h3, "command wake");
    fin("sleep");
    wr(8'h04, 32'h01);
    @(posedge i_clk);
    boff <= 1'b1;
    nx;
    nx;
    chk(32'({rmode, txreq, bon}), 32'h4, "bus off reset");
    @(posedge i_clk);
    boff <= 1'b0;
    wr(8'h00, 32'h42);
    nx;
    repeat (127) pls(0);
    nx;
    chk(32'(bon), 32'h0, "127 free not enough");
    pls(0);
    nx;
    chk(32'(bon), 32'h1, "bus on after 128");
    fin("bus off");
    // Hardware reset in mid-run; sync select must survive it
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    i_ccr_host_model.rd(8'h00, q, err);
    chk(q, 32'h61, "sync select kept");
    chk(32'({rmode, bon}), 32'h2, "mid reset mode");
    fin("mid reset");
    test_done;
  end
endmodule
